// File: design/acpr_pkg.sv
/*
 Constants for the codec power, rate and identity register group.
 Assumes a 32-bit AXI4-Lite slave with one aligned word per register index.
*/
// Summary of operation
// - enhancement register holds center and depth levels
// - amp powerdown pin follows bit; serial select blocks it
// - internal clock disable stops clocks until cold reset
// - link powerdown stops bit clock until warm reset
// - mixer powerdown keeps reference; check mixer ready
// - converter powerdown; check DAC ready before data
// - bits 3:0 are read-only section ready flags
// - codec identity latched at power-up from pins
// - slot mapping flag copies mode control bit
// - extended_audio_identity read-only, reads x009h, x209h with slot map set
// - status register has mic ready; resets 4000h
// - rate enables gate their rate registers
// - three rate registers for DAC, ADC, mic
// - written rate decoded from upper five bits
// - rate read returns stored decoded value
// - rate registers reset to BB80h
// - PCM enable low ignores writes, reads BB80h
// - mic enable low ignores writes, reads BB80h
// - modem ID carries identity, zeros elsewhere
// - modem ID write resets modem registers only
package acpr_pkg;
    localparam logic [7:0] ACPR_OFF_ENH = 8'h22;
    localparam logic [7:0] ACPR_OFF_PWR = 8'h26;
    localparam logic [7:0] ACPR_OFF_EXID = 8'h28;
    localparam logic [7:0] ACPR_OFF_EXST = 8'h2A;
    localparam logic [7:0] ACPR_OFF_DACR = 8'h2C;
    localparam logic [7:0] ACPR_OFF_ADCR = 8'h32;
    localparam logic [7:0] ACPR_OFF_MICR = 8'h34;
    localparam logic [7:0] ACPR_OFF_MDID = 8'h3C;
    localparam logic [7:0] ACPR_OFF_MODE = 8'h5E;
    localparam logic [15:0] ACPR_RST_ENH = 16'h0000;
    localparam logic [15:0] ACPR_RST_EXST = 16'h4000;
    localparam logic [15:0] ACPR_RST_RATE = 16'hBB80;
    localparam logic [15:0] ACPR_EXID_FIXED = 16'h0209;
    localparam int ACPR_B_EXT_AMP_POWER_OFF = 15;
    localparam int ACPR_B_CLKDIS = 13;
    localparam int ACPR_B_LINKPD = 12;
    localparam int ACPR_B_MIXPD = 10;
    localparam int ACPR_B_CNVPD = 9;
    localparam int ACPR_B_MICROPHONE_CONVERTER_READY = 9;
    localparam int ACPR_B_SLOT_MAPPING_FLAG = 7;
    localparam int ACPR_B_SLOT_MAPPING_FLAG_ID = 9;
    localparam int ACPR_B_VRM = 3;
    localparam int ACPR_B_VRA = 0;
    localparam logic [15:0] ACPR_PWR_WMASK = 16'hBF00;
    localparam logic [15:0] ACPR_EXST_WMASK = 16'h4009;
    localparam logic [15:0] ACPR_ENH_WMASK = 16'h0F0F;
    localparam logic [1:0] ACPR_RESP_OKAY = 2'b00;
    localparam logic [1:0] ACPR_RESP_SLVERR = 2'b10;
endpackage

// File: design/acpr_regs.sv
/*
 Power, rate and identity register group of the codec.
 Assumes AXI4-Lite master on aclk; status inputs and pins are
 asynchronous and synchronised here; link clock arrives as a pin.
*/
// Chosen here: the AXI4-Lite slave port.
module acpr_regs
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [8:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [8:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] codec_identity_pins,
    input wire logic serial_clock_select_bit,
    input wire logic [3:0] section_ready,
    input wire logic microphone_converter_ready,
    input wire logic bit_clk_in,
    input wire logic warm_reset_sync,
    output logic ext_amp_power_off,
    output logic internal_clock_stop,
    output logic link_clock_stop,
    output logic mixer_power_off,
    output logic converter_power_off,
    output logic modem_regs_reset,
    output logic bit_clk_seen
);
    import acpr_pkg::*;

    logic [1:0] ssel_sync_reg;
    logic [3:0] rdy_s1_reg;
    logic [3:0] rdy_s2_reg;
    logic [1:0] microphone_converter_ready_sync_reg;
    logic [1:0] sync_sync_reg;
    logic [2:0] bclk_sync_reg;
    logic [1:0] id_s1_reg;
    logic [1:0] id_s2_reg;
    logic [1:0] codec_identity;
    logic id_taken_reg;
    logic [15:0] enh_reg;
    logic [15:0] pwr_reg;
    logic [15:0] exst_reg;
    logic [15:0] dac_rate_reg;
    logic [15:0] adc_rate_reg;
    logic [15:0] mic_rate_reg;
    logic slot_map_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic [8:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_fire;
    logic [15:0] wval;
    logic wr_hit;
    logic [15:0] rd_val;
    logic rd_hit;
    logic ssel;
    logic variable_rate_pcm_enable;
    logic variable_rate_microphone_enable;

    // rate decode on the upper five bits only
    function automatic logic [15:0] rate_decode(input logic [4:0] code);
        logic [15:0] r;
        r = ACPR_RST_RATE;
        if (code <= 5'h03)
            r = 16'h1F40;
        else if (code == 5'h04)
            r = 16'h2580;
        else if (code == 5'h05)
            r = 16'h2B11;
        else if (code == 5'h06)
            r = 16'h3592;
        else if (code <= 5'h08)
            r = 16'h3E80;
        else if (code <= 5'h0A)
            r = 16'h5622;
        else if (code <= 5'h0D)
            r = 16'h5DC0;
        else if (code <= 5'h11)
            r = 16'h7D00;
        else if (code <= 5'h15)
            r = 16'hAC44;
        return r;
    endfunction

    // two-flop synchronisers, three flops for the bit clock; first stage read only by second
    always_ff @(posedge aclk)
    begin
        ssel_sync_reg <= {ssel_sync_reg[0], serial_clock_select_bit};
        rdy_s1_reg <= section_ready;
        rdy_s2_reg <= rdy_s1_reg;
        microphone_converter_ready_sync_reg <= {microphone_converter_ready_sync_reg[0], microphone_converter_ready};
        sync_sync_reg <= {sync_sync_reg[0], warm_reset_sync};
        bclk_sync_reg <= {bclk_sync_reg[1:0], bit_clk_in};
        id_s1_reg <= codec_identity_pins;
        id_s2_reg <= id_s1_reg;
    end
    assign ssel = ssel_sync_reg[1];

    // identity caught once after reset release, then frozen
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            id_taken_reg <= 1'b0;
            codec_identity <= 2'b00;
        end
        else if (!id_taken_reg)
        begin
            id_taken_reg <= 1'b1;
            codec_identity <= id_s2_reg;
        end
    end

    // write channel capture, either order
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 9'h000;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end
        else if (wr_fire)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
        end
    end
    assign wr_fire = aw_held_reg && w_held_reg;

    // byte strobes merge onto the current 16-bit value; the word index
    // of the address picks the register, unmapped words answer SLVERR
    always_comb
    begin
        wr_hit = 1'b1;
        wval = 16'h0000;
        case ({1'b0, awaddr_reg[8:2]})
            ACPR_OFF_ENH: wval = enh_reg;
            ACPR_OFF_PWR: wval = pwr_reg;
            ACPR_OFF_EXST: wval = exst_reg;
            ACPR_OFF_DACR: wval = dac_rate_reg;
            ACPR_OFF_ADCR: wval = adc_rate_reg;
            ACPR_OFF_MICR: wval = mic_rate_reg;
            ACPR_OFF_MODE: wval = {8'h00, slot_map_reg, 7'h00};
            ACPR_OFF_EXID, ACPR_OFF_MDID: wval = 16'h0000;
            default: wr_hit = 1'b0;
        endcase
        if (wstrb_reg[0])
            wval[7:0] = wdata_reg[7:0];
        if (wstrb_reg[1])
            wval[15:8] = wdata_reg[15:8];
    end

    // register indexes are word indexes: byte address = 4 * index
    function automatic logic is_reg(input logic [8:0] a, input logic [7:0] idx);
        return a[8:2] == idx[6:0];
    endfunction

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ACPR_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? ACPR_RESP_OKAY : ACPR_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // rate words need the upper lane: the rate code sits in bits 15:11
    logic w_enh;
    logic w_pwr;
    logic w_exst;
    logic w_dac;
    logic w_adc;
    logic w_mic;
    logic w_mdid;
    logic w_mode;
    assign w_enh = wr_fire && is_reg(awaddr_reg, ACPR_OFF_ENH) && |wstrb_reg[1:0];
    assign w_pwr = wr_fire && is_reg(awaddr_reg, ACPR_OFF_PWR) && |wstrb_reg[1:0];
    assign w_exst = wr_fire && is_reg(awaddr_reg, ACPR_OFF_EXST) && |wstrb_reg[1:0];
    assign w_dac = wr_fire && is_reg(awaddr_reg, ACPR_OFF_DACR) && wstrb_reg[1];
    assign w_adc = wr_fire && is_reg(awaddr_reg, ACPR_OFF_ADCR) && wstrb_reg[1];
    assign w_mic = wr_fire && is_reg(awaddr_reg, ACPR_OFF_MICR) && wstrb_reg[1];
    assign w_mdid = wr_fire && is_reg(awaddr_reg, ACPR_OFF_MDID);
    assign w_mode = wr_fire && is_reg(awaddr_reg, ACPR_OFF_MODE) && wstrb_reg[0];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            enh_reg <= ACPR_RST_ENH;
        else if (w_enh)
            enh_reg <= wval & ACPR_ENH_WMASK;
    end

    // clock disable is cleared only by the cold reset pin (aresetn)
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pwr_reg <= 16'h0000;
        else
        begin
            if (w_pwr)
                pwr_reg <= (wval & ACPR_PWR_WMASK) | (pwr_reg & (16'h0001 << ACPR_B_CLKDIS));
            if (w_pwr && ssel)
                pwr_reg[ACPR_B_EXT_AMP_POWER_OFF] <= 1'b0;
            if (ssel)
                pwr_reg[ACPR_B_EXT_AMP_POWER_OFF] <= 1'b0;
            if (sync_sync_reg[1])
                pwr_reg[ACPR_B_LINKPD] <= 1'b0;
        end
    end

    assign ext_amp_power_off = pwr_reg[ACPR_B_EXT_AMP_POWER_OFF];
    assign internal_clock_stop = pwr_reg[ACPR_B_CLKDIS];
    assign link_clock_stop = pwr_reg[ACPR_B_LINKPD] | pwr_reg[ACPR_B_CLKDIS];
    assign mixer_power_off = pwr_reg[ACPR_B_MIXPD];
    assign converter_power_off = pwr_reg[ACPR_B_CNVPD];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            exst_reg <= ACPR_RST_EXST;
        else if (w_exst)
            exst_reg <= wval & ACPR_EXST_WMASK;
    end
    assign variable_rate_pcm_enable = exst_reg[ACPR_B_VRA];
    assign variable_rate_microphone_enable = exst_reg[ACPR_B_VRM];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            slot_map_reg <= 1'b0;
        else if (w_mode)
            slot_map_reg <= wval[ACPR_B_SLOT_MAPPING_FLAG];
    end

    // clearing an enable returns its rates to default
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !variable_rate_pcm_enable)
        begin
            dac_rate_reg <= ACPR_RST_RATE;
            adc_rate_reg <= ACPR_RST_RATE;
        end
        else
        begin
            if (w_dac)
                dac_rate_reg <= rate_decode(wval[15:11]);
            if (w_adc)
                adc_rate_reg <= rate_decode(wval[15:11]);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !variable_rate_microphone_enable)
            mic_rate_reg <= ACPR_RST_RATE;
        else if (w_mic)
            mic_rate_reg <= rate_decode(wval[15:11]);
    end

    // one-cycle modem register reset; audio state untouched
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            modem_regs_reset <= 1'b0;
        else
            modem_regs_reset <= w_mdid;
    end

    // bit clock activity; a stopped link wins, so the edge of the
    // clock parking low never reads as activity
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            bit_clk_seen <= 1'b0;
        else if (link_clock_stop)
            bit_clk_seen <= 1'b0;
        else if (bclk_sync_reg[2] != bclk_sync_reg[1])
            bit_clk_seen <= 1'b1;
    end

    // read path
    always_comb
    begin
        rd_hit = 1'b1;
        rd_val = 16'h0000;
        if (is_reg(s_axi_araddr, ACPR_OFF_ENH))
            rd_val = enh_reg;
        else if (is_reg(s_axi_araddr, ACPR_OFF_PWR))
            rd_val = {pwr_reg[15:4], rdy_s2_reg};
        else if (is_reg(s_axi_araddr, ACPR_OFF_EXID))
        begin
            rd_val = ACPR_EXID_FIXED | {codec_identity, 14'h0000};
            rd_val[ACPR_B_SLOT_MAPPING_FLAG_ID] = slot_map_reg;
        end
        else if (is_reg(s_axi_araddr, ACPR_OFF_EXST))
        begin
            rd_val = exst_reg;
            rd_val[ACPR_B_MICROPHONE_CONVERTER_READY] = microphone_converter_ready_sync_reg[1];
        end
        else if (is_reg(s_axi_araddr, ACPR_OFF_DACR))
            rd_val = dac_rate_reg;
        else if (is_reg(s_axi_araddr, ACPR_OFF_ADCR))
            rd_val = adc_rate_reg;
        else if (is_reg(s_axi_araddr, ACPR_OFF_MICR))
            rd_val = mic_rate_reg;
        else if (is_reg(s_axi_araddr, ACPR_OFF_MDID))
            rd_val = {codec_identity, 14'h0000};
        else if (is_reg(s_axi_araddr, ACPR_OFF_MODE))
            rd_val = {8'h00, slot_map_reg, 7'h00};
        else
            rd_hit = 1'b0;
    end

    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ACPR_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, rd_val};
            s_axi_rresp <= rd_hit ? ACPR_RESP_OKAY : ACPR_RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule

// File: test/acpr_regs_monitor.sv
/*
 Concurrent checks on the ports of the power, rate and identity registers.
 Assumes it is bound onto acpr_regs, clocked by aclk, reset by aresetn.
*/
module acpr_regs_monitor
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic serial_clock_select_bit,
    input wire logic ext_amp_power_off,
    input wire logic internal_clock_stop,
    input wire logic link_clock_stop,
    input wire logic modem_regs_reset,
    input wire logic bit_clk_seen
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // serial select needs a few cycles to pass its synchroniser
    a_amp_blocked: assert property (serial_clock_select_bit [*5] |-> !ext_amp_power_off)
        else $error("amp powerdown high while serial select held");
    a_clkdis_sticky: assert property (internal_clock_stop |=> internal_clock_stop)
        else $error("clock disable released without cold reset");
    a_clkdis_link: assert property (internal_clock_stop |-> link_clock_stop)
        else $error("bit clock not stopped with internal clock");
    a_bitclk_clear: assert property (link_clock_stop [*3] |-> !bit_clk_seen)
        else $error("bit clock activity reported while link down");
    a_modem_pulse: assert property (modem_regs_reset |=> !modem_regs_reset)
        else $error("modem reset wider than one cycle");
    a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read lanes not zero");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");
endmodule

bind acpr_regs acpr_regs_monitor i_acpr_regs_monitor (.*);

// File: test/acpr_link_model.sv
/*
 Behavioural link controller: bit clock source and warm reset strobe.
 Assumes the bench calls warm_reset to restart a powered-down link.
*/
module acpr_link_model
#(
    parameter int WARM_NS = 200
)
(
    input wire logic link_clock_stop,
    input wire logic internal_clock_stop,
    output logic bit_clk_in,
    output logic warm_reset_sync
);
    timeunit 1ns;
    timeprecision 100ps;
    // odd start offset keeps the link clock unrelated to aclk
    initial
    begin
        bit_clk_in = 1'b0;
        warm_reset_sync = 1'b0;
        #13;
        forever
        begin
            #32;
            if (link_clock_stop || internal_clock_stop)
                bit_clk_in = 1'b0;
            else
                bit_clk_in = ~bit_clk_in;
        end
    end
    task automatic warm_reset();
        warm_reset_sync = 1'b1;
        #(WARM_NS);
        warm_reset_sync = 1'b0;
    endtask
endmodule

// File: test/acpr_regs_tb.sv
/*
 Self-checking bench of the power, rate and identity register group.
 Assumes acpr_regs, the bound monitor and the link model are compiled.
*/
module acpr_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import acpr_pkg::*;
    typedef struct {logic [7:0] a; logic [15:0] d; logic [15:0] e;} acpr_row_s;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [8:0] s_axi_awaddr = 9'h000, s_axi_araddr = 9'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [1:0] codec_identity_pins = 2'h2;
    logic serial_clock_select_bit = 1'b0, microphone_converter_ready = 1'b1;
    logic [3:0] section_ready = 4'hA;
    logic bit_clk_in, warm_reset_sync, ext_amp_power_off, internal_clock_stop;
    logic link_clock_stop, mixer_power_off, converter_power_off, modem_regs_reset;
    logic bit_clk_seen;
    logic [31:0] rd;
    int num_errors = 0, checks = 0, pulses = 0, p0;
    acpr_row_s rows[13] = '{'{8'h22, 16'h070C, 16'h070C}, '{8'h22, 16'hFFFF, 16'h0F0F},
        '{8'h2C, 16'h1FFF, 16'h1F40}, '{8'h2C, 16'h2000, 16'h2580},
        '{8'h32, 16'h2FFF, 16'h2B11}, '{8'h32, 16'h3000, 16'h3592},
        '{8'h34, 16'h47FF, 16'h3E80}, '{8'h34, 16'h4800, 16'h5622},
        '{8'h2C, 16'h6FFF, 16'h5DC0}, '{8'h32, 16'h7000, 16'h7D00},
        '{8'h34, 16'hAFFF, 16'hAC44}, '{8'h2C, 16'hB000, 16'hBB80},
        '{8'h32, 16'h3800, 16'h3E80}};

    acpr_regs i_acpr_regs (.*);
    acpr_link_model i_acpr_link_model (.link_clock_stop(link_clock_stop),
        .internal_clock_stop(internal_clock_stop), .bit_clk_in(bit_clk_in),
        .warm_reset_sync(warm_reset_sync));

    initial
    begin
        forever #2.5 aclk = ~aclk;
    end
    always @(posedge aclk)
        if (modem_regs_reset === 1'b1)
            pulses <= pulses + 1;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // requests qualified at the falling edge, released after the taking edge
    // a is a register index: the byte address is four times it
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bit aw_t, w_t, b_t;
        int n;
        n = 0;
        b_t = 0;
        s_axi_awaddr <= {a[6:0], 2'b00};
        s_axi_wdata <= {16'h0000, d};
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b_t && n < 100)
        begin
            @(negedge aclk);
            aw_t = s_axi_awvalid && s_axi_awready;
            w_t = s_axi_wvalid && s_axi_wready;
            b_t = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (aw_t)
                s_axi_awvalid <= 1'b0;
            if (w_t)
                s_axi_wvalid <= 1'b0;
            n++;
        end
        s_axi_bready <= 1'b0;
        chk("write answered", 1, b_t);
        @(posedge aclk);
    endtask
    task automatic rdw(input logic [7:0] a);
        bit ar_t, r_t;
        int n;
        n = 0;
        r_t = 0;
        s_axi_araddr <= {a[6:0], 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r_t && n < 100)
        begin
            @(negedge aclk);
            ar_t = s_axi_arvalid && s_axi_arready;
            r_t = s_axi_rvalid;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (ar_t)
                s_axi_arvalid <= 1'b0;
            n++;
        end
        s_axi_rready <= 1'b0;
        chk("read answered", 1, r_t);
        @(posedge aclk);
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        rdw(a);
        chk(what, exp, rd);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        #100000;
        num_errors++;
        $display("Error watchdog expired");
        report_and_stop();
    end

    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("outputs idle", 0, {ext_amp_power_off, internal_clock_stop, link_clock_stop});
        foreach (rows[i])
        begin
            if (i > 1)
                rdchk("rate reset", rows[i].a, 32'hBB80);
        end
        rdchk("enhance reset", 8'h22, 32'h0000);
        rdchk("ext status reset", 8'h2A, 32'h4200);
        rdchk("modem id", 8'h3C, 32'h8000);
        wr(8'h5E, 16'h0080);
        rdchk("ext id", 8'h28, 32'h8209);
        wr(8'h5E, 16'h0000);
        rdchk("ext id map", 8'h28, 32'h8009);
        $display("test reset values done");
        wr(8'h2C, 16'h1000);
        rdchk("dac gated", 8'h2C, 32'hBB80);
        wr(8'h34, 16'h1000);
        rdchk("mic gated", 8'h34, 32'hBB80);
        wr(8'h2A, 16'h0008);
        wr(8'h34, 16'h1000);
        rdchk("mic open", 8'h34, 32'h1F40);
        wr(8'h32, 16'h1000);
        rdchk("adc gated", 8'h32, 32'hBB80);
        wr(8'h2A, 16'h0009);
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            rdchk("row", rows[i].a, {16'h0000, rows[i].e});
        end
        wr(8'h2A, 16'h0000);
        rdchk("dac restored", 8'h2C, 32'hBB80);
        microphone_converter_ready <= 1'b0;
        repeat (3) @(posedge aclk);
        rdchk("mic ready low", 8'h2A, 32'h0000);
        $display("test rates done");
        wr(8'h26, 16'h0600);
        chk("mixer dac off", 2'h3, {mixer_power_off, converter_power_off});
        rdchk("power", 8'h26, 32'h060A);
        section_ready <= 4'h5;
        repeat (5) @(posedge aclk);
        rdchk("ready flags", 8'h26, 32'h0605);
        wr(8'h26, 16'h8000);
        chk("amp off", 1, ext_amp_power_off);
        serial_clock_select_bit <= 1'b1;
        repeat (8) @(posedge aclk);
        chk("amp blocked", 0, ext_amp_power_off);
        wr(8'h26, 16'h8000);
        rdchk("amp reads zero", 8'h26, 32'h0005);
        serial_clock_select_bit <= 1'b0;
        wr(8'h26, 16'h1000);
        repeat (8) @(posedge aclk);
        chk("link down", 2'h2, {link_clock_stop, bit_clk_seen});
        i_acpr_link_model.warm_reset();
        repeat (60) @(posedge aclk);
        chk("link up", 2'h1, {link_clock_stop, bit_clk_seen});
        $display("test power done");
        p0 = pulses;
        wr(8'h3C, 16'h1234);
        repeat (3) @(posedge aclk);
        chk("modem resets", 1, pulses - p0);
        rdchk("modem id kept", 8'h3C, 32'h8000);
        rdchk("audio kept", 8'h22, 32'h0F0F);
        wr(8'h40, 16'h0001);
        chk("unmapped write", ACPR_RESP_SLVERR, resp);
        rdchk("unmapped read", 8'h40, 32'h0);
        chk("unmapped resp", ACPR_RESP_SLVERR, resp);
        wr(8'h26, 16'h2000);
        wr(8'h26, 16'h0000);
        chk("clock held off", 2'h3, {internal_clock_stop, link_clock_stop});
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("cold reset", 0, internal_clock_stop);
        rdchk("rate after reset", 8'h2C, 32'hBB80);
        $display("test modem and clock disable done");
        report_and_stop();
    end
endmodule
